// file: src/smbarm_pkg.sv
// package of constants and types for the alert response mask block
// Functional notes
// RQ1 - alert gated by register mask and auto mask
// RQ2 - auto mask set only on own ARA win
// RQ3 - ARA read returns own bus address
// RQ4 - release alert line after winning ARA read
// RQ5 - auto mask covers faults active at read
// RQ6 - status still reports masked faults
// RQ7 - auto mask cleared only by clear faults
// RQ8 - host should routinely send clear faults
// RQ9 - address chosen from three tri-level straps
// RQ10 - alert when unmasked fault is active
package smbarm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register map
    localparam logic [7:0]  SMBARM_MASK_CMD   = 8'hd8;   // alert mask command code
    localparam int          SMBARM_FAULTS     = 16;      // fault condition count
    localparam logic [15:0] SMBARM_MASK_RESET = 16'h0000; // mask after reset

    ////////////////////////////////////////////////////////////////////////////
    // tri-level strap encoding
    localparam logic [1:0]  SMBARM_LVL_LOW    = 2'h0;
    localparam logic [1:0]  SMBARM_LVL_HIGH   = 2'h1;
    localparam logic [1:0]  SMBARM_LVL_OPEN   = 2'h2;

    // strap synchroniser for one tri-level pin: drive/sense pairs
    typedef struct packed {
        logic [2:0] hi_sync;    // pin read with weak pull-down
        logic [2:0] lo_sync;    // pin read with weak pull-up
    } smbarm_strap_type;

    // state of the top module
    typedef struct packed {
        logic [15:0] fault_alert_mask;  // software mask
        logic [15:0] auto_alert_mask;   // hardware mask
        logic [6:0]  own_addr;          // decoded bus address
        logic        alert_line;        // active high alert request
        logic        ara_valid;         // ara answer ready
        logic [6:0]  ara_addr;          // answered address
        logic [15:0] status;            // reported faults
        logic [15:0] mask_rdata;        // mask read back
    } smbarm_state_type;

endpackage

// file: src/smbarm_strap.sv
// tri-level strap sampler: three stage sync, accepts when stages 2 and 3 agree
`timescale 1ns/1ps
module smbarm_strap
    import smbarm_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // pin sense, read with pull-up and pull-down
    input  wire logic       sense_hi,
    input  wire logic       sense_lo,
    // decoded level
    output logic [1:0]      level
);

    smbarm_strap_type state;       // synchroniser stages
    smbarm_strap_type next_state;  // next synchroniser stages
    logic [1:0]       next_level;  // next decoded level

    ////////////////////////////////////////////////////////////////////////////
    // shift stages, decode when settled
    always_comb begin
        next_state.hi_sync = {state.hi_sync[1:0], sense_hi};
        next_state.lo_sync = {state.lo_sync[1:0], sense_lo};
        next_level = level;
        // only stages 2 and 3 are inspected
        if (state.hi_sync[2] == state.hi_sync[1] && state.lo_sync[2] == state.lo_sync[1]) begin
            if (state.hi_sync[2] && state.lo_sync[2]) begin
                next_level = SMBARM_LVL_HIGH;   // high under both pulls
            end else if (!state.hi_sync[2] && !state.lo_sync[2]) begin
                next_level = SMBARM_LVL_LOW;    // low under both pulls
            end else begin
                next_level = SMBARM_LVL_OPEN;   // follows the pull
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register stages
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= '0;
            level <= SMBARM_LVL_OPEN;
        end else begin
            state <= next_state;
            level <= next_level;
        end
    end

endmodule // smbarm_strap

// file: src/smbarm_top.sv
// alert line masking and alert response logic
`timescale 1ns/1ps
module smbarm_top
    import smbarm_pkg::*;
#(
    parameter int FAULTS = SMBARM_FAULTS
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // address straps, sensed under pull-up and pull-down
    input  wire logic [2:0]  strap_sense_hi,
    input  wire logic [2:0]  strap_sense_lo,
    // fault conditions from monitors
    input  wire logic [15:0] fault_active,
    // command decode from bus slave
    input  wire logic        cmd_write,
    input  wire logic        cmd_read,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    input  wire logic        clear_faults,
    // alert response read from bus slave
    input  wire logic        ara_start,
    input  wire logic        ara_won,
    // outputs
    output logic             alert_line,
    output logic             alert_line_oe,
    output logic             ara_valid,
    output logic [6:0]       ara_addr,
    output logic [6:0]       own_addr,
    output logic [15:0]      status,
    output logic [15:0]      mask_rdata
);

    smbarm_state_type state;       // registered state
    smbarm_state_type next_state;  // next state
    logic [1:0]       lvl [3];     // strap levels, index 0..2
    logic [6:0]       dec_addr;    // address from straps
    logic [15:0]      unmasked;    // faults able to alert
    logic             next_oe;     // next open-drain enable

    ////////////////////////////////////////////////////////////////////////////
    // strap samplers
    for (genvar i = 0; i < 3; i++) begin : g_strap
        smbarm_strap u_strap (
            .clock    (clock),
            .rst      (rst),
            .sense_hi (strap_sense_hi[i]),
            .sense_lo (strap_sense_lo[i]),
            .level    (lvl[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // base-3 strap index: open counts 0, low 1, high 2
    function automatic logic [4:0] trit(input logic [1:0] l);
        trit = (l == SMBARM_LVL_OPEN) ? 5'h00 : (l == SMBARM_LVL_LOW) ? 5'h01 : 5'h02;
    endfunction

    // address table indexed by strap combination
    always_comb begin
        logic [4:0] idx;
        idx = 5'h00;
        idx = 5'(trit(lvl[2]) * 5'h09 + trit(lvl[1]) * 5'h03 + trit(lvl[0])); // RQ9
        case (idx)
            // strap 2 open
            5'h00: dec_addr = 7'h40;
            5'h01: dec_addr = 7'h41;
            5'h02: dec_addr = 7'h42;
            5'h03: dec_addr = 7'h43;
            5'h04: dec_addr = 7'h44;
            5'h05: dec_addr = 7'h45;
            5'h06: dec_addr = 7'h46;
            5'h07: dec_addr = 7'h47;
            5'h08: dec_addr = 7'h10;
            // strap 2 low
            5'h09: dec_addr = 7'h11;
            5'h0a: dec_addr = 7'h12;
            5'h0b: dec_addr = 7'h13;
            5'h0c: dec_addr = 7'h14;
            5'h0d: dec_addr = 7'h15;
            5'h0e: dec_addr = 7'h16;
            5'h0f: dec_addr = 7'h17;
            // strap 2 high, after the shared code
            5'h15: dec_addr = 7'h56;
            5'h16: dec_addr = 7'h56;
            5'h17: dec_addr = 7'h57;
            5'h18: dec_addr = 7'h58;
            5'h19: dec_addr = 7'h59;
            5'h1a: dec_addr = 7'h5a;
            default: dec_addr = 7'h53;  // shared code of five combinations
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_state = state;
        next_state.own_addr = dec_addr;
        // status follows faults regardless of masks
        next_state.status = fault_active; // RQ6
        // software mask register
        if (cmd_write && cmd_code == SMBARM_MASK_CMD) begin
            next_state.fault_alert_mask = cmd_wdata; // RQ1
        end
        if (cmd_read && cmd_code == SMBARM_MASK_CMD) begin
            next_state.mask_rdata = state.fault_alert_mask;
        end
        // ara answer carries own address while alerting
        next_state.ara_valid = ara_start && state.alert_line; // RQ3
        next_state.ara_addr  = state.own_addr; // RQ3
        // auto mask: clear faults first, winning read sets over it
        if (clear_faults) begin
            next_state.auto_alert_mask = '0; // RQ7
        end
        if (ara_won && state.alert_line) begin
            next_state.auto_alert_mask = (clear_faults ? 16'h0000 : state.auto_alert_mask)
                                         | fault_active; // RQ2 RQ5
        end
        // alert from faults clear in both masks
        next_state.alert_line = |(fault_active & ~next_state.fault_alert_mask
                                  & ~next_state.auto_alert_mask); // RQ10 RQ1 RQ4 RQ7
    end

    assign unmasked = fault_active & ~state.fault_alert_mask & ~state.auto_alert_mask;
    assign next_oe  = next_state.alert_line;

    ////////////////////////////////////////////////////////////////////////////
    // register state
    always_ff @(posedge clock) begin
        if (rst) begin
            // sync reset: masks cleared, alert released
            state <= '0;
            state.fault_alert_mask <= SMBARM_MASK_RESET;
            alert_line_oe <= 1'b0;
        end else begin
            // normal update every edge
            state <= next_state;
            alert_line_oe <= next_oe;
        end
    end

    assign alert_line = state.alert_line;
    assign ara_valid  = state.ara_valid;
    assign ara_addr   = state.ara_addr;
    assign own_addr   = state.own_addr;
    assign status     = state.status;
    assign mask_rdata = state.mask_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    // alert follows faults clear in both masks
    AST_GATE: assert property (@(posedge clock) disable iff (rst) // RQ10
        ##1 alert_line == |$past(unmasked) || $past(ara_won) || $past(clear_faults)
            || $past(cmd_write))
        else $error("alert does not follow unmasked faults");
    // winning read drops the alert
    AST_RELEASE: assert property (@(posedge clock) disable iff (rst) // RQ4
        (ara_won && alert_line && !clear_faults) |=> !alert_line)
        else $error("alert not released after won ara read");
    // every fault active at the read is masked
    AST_AUTOSET: assert property (@(posedge clock) disable iff (rst) // RQ5
        (ara_won && alert_line) |=> ((state.auto_alert_mask & $past(fault_active))
                                     == $past(fault_active)))
        else $error("auto mask misses active faults");
    // no new auto mask bits without a won read
    AST_ONLYWIN: assert property (@(posedge clock) disable iff (rst) // RQ2
        !(ara_won && alert_line) |=> (state.auto_alert_mask & ~$past(state.auto_alert_mask))
                                     == 16'h0000)
        else $error("auto mask set without won read");
    // auto mask bits survive until clear faults
    AST_HOLD: assert property (@(posedge clock) disable iff (rst) // RQ7
        (!clear_faults && |state.auto_alert_mask) |=>
            ((state.auto_alert_mask & $past(state.auto_alert_mask))
             == $past(state.auto_alert_mask)))
        else $error("auto mask cleared without clear faults");
    // clear faults empties the auto mask
    AST_CLEAR: assert property (@(posedge clock) disable iff (rst) // RQ7
        (clear_faults && !ara_won) |=> state.auto_alert_mask == 16'h0000)
        else $error("clear faults did not clear auto mask");
    // status ignores both masks
    AST_STATUS: assert property (@(posedge clock) disable iff (rst) // RQ6
        ##1 status == $past(fault_active))
        else $error("status hides a fault");
    // alerting device answers with its own address
    AST_ARA: assert property (@(posedge clock) disable iff (rst) // RQ3
        (ara_start && alert_line) |=> (ara_valid && ara_addr == $past(own_addr)))
        else $error("ara answer wrong");
    // mask register takes the written word
    AST_MASK: assert property (@(posedge clock) disable iff (rst) // RQ1
        (cmd_write && cmd_code == SMBARM_MASK_CMD) |=> state.fault_alert_mask == $past(cmd_wdata))
        else $error("mask register not written");
    // no answer while not alerting
    AST_NOARA: assert property (@(posedge clock) disable iff (rst) // RQ3
        !(ara_start && alert_line) |=> !ara_valid)
        else $error("ara answer without alert");
    // won read together with clear faults: set wins
    AST_SETWINS: assert property (@(posedge clock) disable iff (rst) // RQ7
        (clear_faults && ara_won && alert_line)
            |=> state.auto_alert_mask == $past(fault_active))
        else $error("clear faults beat a won read");
    // mask register keeps its value without a write to its code
    AST_MASKKEEP: assert property (@(posedge clock) disable iff (rst) // RQ1
        !(cmd_write && cmd_code == SMBARM_MASK_CMD)
            |=> state.fault_alert_mask == $past(state.fault_alert_mask))
        else $error("mask register changed without write");
    // read back carries the mask register
    AST_RDATA: assert property (@(posedge clock) disable iff (rst) // RQ1
        (cmd_read && cmd_code == SMBARM_MASK_CMD)
            |=> mask_rdata == $past(state.fault_alert_mask))
        else $error("mask read back wrong");
    // lost or refused read leaves the auto mask alone
    AST_NOWIN: assert property (@(posedge clock) disable iff (rst) // RQ2
        (!(ara_won && alert_line) && !clear_faults)
            |=> state.auto_alert_mask == $past(state.auto_alert_mask))
        else $error("auto mask moved without won read or clear");
    // alert stays down while every active fault is masked
    AST_QUIET: assert property (@(posedge clock) disable iff (rst) // RQ7
        ((fault_active & ~state.fault_alert_mask & ~state.auto_alert_mask) == 16'h0000
            && !cmd_write && !clear_faults) |=> !alert_line)
        else $error("alert raised by a masked fault");

endmodule // smbarm_top

// file: verification/smbarm_host.sv
// host model that services alerts: response reads and clear faults
`timescale 1ns/1ps
module smbarm_host
    import smbarm_pkg::*;
(
    // clock
    input  wire logic       clock,
    // answer from the device
    input  wire logic       ara_valid,
    input  wire logic [6:0] ara_addr,
    // requests to the device
    output logic            ara_start,
    output logic            ara_won,
    output logic            clear_faults
);
    ////////////////////////////////////////////////////////////////////////////
    // idle requests from time zero
    initial begin
        ara_start    = 1'b0;
        ara_won      = 1'b0;
        clear_faults = 1'b0;
    end

    // one response read; a rival on the bus holds address rival
    task automatic ara_read(input logic [6:0] rival, output logic got, output logic won);
        got = 1'b0;
        won = 1'b0;
        @(negedge clock) ara_start = 1'b1;
        // answer stands one cycle, so look at every edge
        repeat (3) begin
            @(posedge clock) #1;
            if (ara_valid === 1'b1) begin
                got = 1'b1;
                won = (ara_addr < rival);
            end
            @(negedge clock) ara_start = 1'b0;
        end
        // lowest address wins the bus
        ara_won = won;
        @(negedge clock) ara_won = 1'b0;
    endtask

    // routine clear after servicing an alert
    task automatic clear();
        @(negedge clock) clear_faults = 1'b1;
        @(negedge clock) clear_faults = 1'b0;
    endtask
endmodule // smbarm_host

// file: verification/tb.sv
// self-checking bench for the alert response mask block
`timescale 1ns/1ps
module tb;
    import smbarm_pkg::*;
    // strap decode table, index 9*s2+3*s1+s0, open=0 low=1 high=2
    localparam logic [6:0] ADDR_TBL [27] = '{7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h45,
        7'h46, 7'h47, 7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17, 7'h53,
        7'h53, 7'h53, 7'h53, 7'h53, 7'h56, 7'h56, 7'h57, 7'h58, 7'h59, 7'h5a};
    logic        clock, rst, cmd_write, cmd_read, clear_faults, ara_start, ara_won;
    logic [2:0]  strap_sense_hi, strap_sense_lo;
    logic [15:0] fault_active, cmd_wdata, status, mask_rdata, mask_sw, flt;
    logic [7:0]  cmd_code;
    logic        alert_line, alert_line_oe, ara_valid, ans, win;
    logic [6:0]  ara_addr, own_addr;
    int          bad_count, checks, cycles, i, lv;

    smbarm_top i_smbarm_top (.clock(clock), .rst(rst), .strap_sense_hi(strap_sense_hi),
        .strap_sense_lo(strap_sense_lo), .fault_active(fault_active), .cmd_write(cmd_write),
        .cmd_read(cmd_read), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .clear_faults(clear_faults), .ara_start(ara_start), .ara_won(ara_won),
        .alert_line(alert_line), .alert_line_oe(alert_line_oe), .ara_valid(ara_valid),
        .ara_addr(ara_addr), .own_addr(own_addr), .status(status), .mask_rdata(mask_rdata));
    smbarm_host i_smbarm_host (.clock(clock), .ara_valid(ara_valid), .ara_addr(ara_addr),
        .ara_start(ara_start), .ara_won(ara_won), .clear_faults(clear_faults));

    ////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            close_out();
        end
    end

    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // command pulse, then let the answer land
    task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] d);
        @(negedge clock);
        cmd_write = wr;
        cmd_read  = ~wr;
        cmd_code  = code;
        cmd_wdata = d;
        @(negedge clock);
        cmd_write = 1'b0;
        cmd_read  = 1'b0;
        repeat (2) @(negedge clock);
    endtask
    // expected alert level from faults and the register mask
    function automatic logic alert_exp(input logic [15:0] f, input logic [15:0] m);
        alert_exp = |(f & ~m);
    endfunction
    // new fault levels, then wait for status and alert
    task automatic settle(input logic [15:0] f);
        fault_active = f;
        repeat (3) @(negedge clock);
    endtask
    // counts, verdict, end of run
    task automatic close_out();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        void'($urandom(32'h1194));
        {rst, cmd_write, cmd_read, cmd_code, cmd_wdata} = {1'b1, 26'h0};
        {strap_sense_hi, strap_sense_lo, fault_active} = 22'h0;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        chk(alert_line, 1'b0);
        // every strap combination
        for (i = 0; i < 27; i++) begin
            for (lv = 0; lv < 3; lv++) begin
                strap_sense_hi[lv] = ((i / (3 ** lv)) % 3) == 2;
                strap_sense_lo[lv] = ((i / (3 ** lv)) % 3) != 1;
            end
            repeat (8) @(negedge clock);
            chk(own_addr, ADDR_TBL[i]);
        end
        // mask register, then an unmapped code
        mask_sw = 16'($urandom);
        cmd(1'b1, SMBARM_MASK_CMD, mask_sw);
        cmd(1'b0, SMBARM_MASK_CMD, 16'h0);
        chk(mask_rdata, mask_sw);
        cmd(1'b1, 8'hd9, ~mask_sw);
        cmd(1'b0, 8'hd9, 16'h0);
        cmd(1'b0, SMBARM_MASK_CMD, 16'h0);
        chk(mask_rdata, mask_sw);
        // random faults under the register mask, first one fully masked
        for (i = 0; i < 20; i++) begin
            settle((i == 0) ? mask_sw : 16'($urandom));
            chk(alert_line, alert_exp(fault_active, mask_sw));
            chk(alert_line_oe, alert_exp(fault_active, mask_sw));
        end
        cmd(1'b1, SMBARM_MASK_CMD, 16'h0);
        // winning read sets the auto mask
        flt = (16'($urandom) & 16'h7fff) | 16'h0001;
        settle(flt);
        i_smbarm_host.ara_read(7'h7f, ans, win);
        chk({ans, win}, 2'b11);
        chk(ara_addr, ADDR_TBL[26]);
        settle(flt);
        chk(alert_line, 1'b0);
        chk(status, flt);
        settle(flt | 16'h8000);
        chk(alert_line, 1'b1);
        settle(flt);
        chk(alert_line, 1'b0);
        // read while not alerting is refused
        i_smbarm_host.ara_read(7'h7f, ans, win);
        chk(ans, 1'b0);
        i_smbarm_host.clear();
        settle(flt);
        chk(alert_line, 1'b1);
        // losing read keeps the alert up
        i_smbarm_host.ara_read(7'h08, ans, win);
        chk({ans, win}, 2'b10);
        settle(flt);
        chk(alert_line, 1'b1);
        // won read and clear faults in one cycle: set wins
        fork
            i_smbarm_host.ara_read(7'h7f, ans, win);
            begin
                repeat (3) @(negedge clock);
                i_smbarm_host.clear();
            end
        join
        chk({ans, win}, 2'b11);
        settle(flt);
        chk(alert_line, 1'b0);
        close_out();
    end
endmodule // tb
